// [common/servo_input_pkg.sv]
package servo_input_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_HZ          = 64'd100_000_000;
  localparam longint WIPE_HOLD_S     = 64'd4;
  localparam longint WIPE_HOLD_CYC   = WIPE_HOLD_S * CLK_HZ;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_GEAR    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_POS_ERR = 8'h0c;
  localparam logic [7:0] OFS_CAP_A   = 8'h10;
  localparam logic [7:0] OFS_CAP_B   = 8'h14;
  localparam logic [7:0] OFS_GEN_AN  = 8'h18;

  // ****************************************
  // config fields
  // ****************************************
  localparam int CFG_SEL_LSB   = 0;   // 7 bits: second-function select per terminal; SEL_PROBE switches two terminals
  localparam int SEL_PEN       = 0;
  localparam int SEL_CER       = 1;
  localparam int SEL_PPI       = 2;
  localparam int SEL_SS1       = 3;
  localparam int SEL_SS2       = 4;
  localparam int SEL_SRZ       = 5;
  localparam int SEL_PROBE     = 6;
  localparam int CFG_PROG_BIT  = 7;
  localparam int CFG_MODE_A    = 8;   // 2 bits
  localparam int CFG_MODE_B    = 10;  // 2 bits
  localparam int CFG_SPD_LIM   = 12;
  localparam int CFG_TRQ_LIM   = 13;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] GEAR_RST   = 32'h0001_0001;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_TRIP    = 0;
  localparam int ST_HOMING  = 1;
  localparam int ST_HOMED   = 2;
  localparam int ST_GEAR2   = 3;
  localparam int ST_STAGE   = 4;  // 2 bits
  localparam int ST_CAP_LSB = 8;  // 2 sticky capture flags

  typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ, MODE_RSV} ctrl_mode_t;
  typedef enum logic [1:0] {ROLE_CMD, ROLE_BIAS, ROLE_LIMIT, ROLE_GENERAL} an_role_t;

endpackage

// [rtl/hold_qualifier.sv]
module hold_qualifier #(
  parameter longint HOLD_CYC = 64'd400_000_000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // level in, one pulse out
  input  wire logic level,
  output logic      fire
);
  localparam int CW = $clog2(HOLD_CYC + 1);

  generate
    if (HOLD_CYC < 1) begin : g_bad
      $error("hold count must be at least one cycle");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  logic          done_r;

  // count restarts on release, fires once per held assertion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
      fire   <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!level) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r == CW'(HOLD_CYC - 1)) begin
          fire   <= 1'b1;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule // hold_qualifier

// [rtl/edge_capture.sv]
module edge_capture #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // probe and position
  input  wire logic         enable,
  input  wire logic         probe,
  input  wire logic [W-1:0] position,
  output logic      [W-1:0] held,
  output logic              hit
);
  logic prev_r;
  wire  any_edge = enable && (probe != prev_r);

  // both edges latch; prev tracks even while disabled so enabling makes no false edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b0;
      held   <= '0;
      hit    <= 1'b0;
    end else begin
      prev_r <= probe;
      hit    <= any_edge;
      if (any_edge) begin
        held <= position;
      end
    end
  end
endmodule // edge_capture

// [rtl/servo_input_terminal_logic.sv]
module servo_input_terminal_logic #(
  parameter int     POS_W            = 32,
  parameter int     AN_W             = 16,
  parameter longint WIPE_HOLD_CYCLES = servo_input_pkg::WIPE_HOLD_CYC
) (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  // register port
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [31:0]       RDATA,
  // shared input terminals
  input  wire logic              HOME_ZONE_SWITCH,
  input  wire logic              HOMING_REQUEST,
  input  wire logic              PULSE_TRAIN_GATE,
  input  wire logic              POSITION_ERROR_CLEAR,
  input  wire logic              PROPORTIONAL_ONLY_SELECT,
  input  wire logic              SPEED_SELECT_A,
  input  wire logic              SPEED_SELECT_B,
  input  wire logic              ZERO_SPEED_CLAMP,
  input  wire logic              CONTROL_LAW_SELECT,
  input  wire logic              TORQUE_LIMIT_ENABLE,
  input  wire logic              ALARM_RESET,
  // position command and feedback
  input  wire logic              CMD_PULSE,
  input  wire logic              CMD_DIR,
  input  wire logic              FB_PULSE,
  input  wire logic              FB_DIR,
  input  wire logic [POS_W-1:0]  ACTUAL_POS,
  // analog inputs as converted codes
  input  wire logic [AN_W-1:0]   ANALOG_IN_SPEED,
  input  wire logic [AN_W-1:0]   ANALOG_IN_TORQUE,
  input  wire logic [AN_W-1:0]   ANALOG_FWD_TORQUE_CAP,
  input  wire logic [AN_W-1:0]   ANALOG_BWD_TORQUE_CAP,
  // drive controls
  output logic      [POS_W-1:0]  POS_ERROR,
  output logic      [1:0]        CTRL_MODE,
  output logic      [1:0]        SPEED_STAGE,
  output logic                   RUN_FWD,
  output logic                   RUN_BWD,
  output logic                   SPEED_CLAMP,
  output logic                   P_ONLY,
  output logic                   GAIN_ALT,
  output logic                   GEAR_TWO,
  output logic                   TRIP,
  output logic                   OUTPUT_STOP,
  output logic                   TURN_COUNT_CLEAR,
  output logic                   HOMING_ACTIVE,
  output logic                   HOMED,
  // analog routing
  output logic      [AN_W-1:0]   SPEED_ANALOG,
  output logic      [1:0]        SPEED_ROLE,
  output logic      [AN_W-1:0]   TORQUE_ANALOG,
  output logic      [1:0]        TORQUE_ROLE,
  output logic                   TORQUE_LIMIT_ON,
  output logic      [AN_W-1:0]   FWD_TORQUE_CAP,
  output logic      [AN_W-1:0]   BWD_TORQUE_CAP
);

  generate
    if (POS_W < 16 || POS_W > 32 || AN_W < 1 || AN_W > 16) begin : g_bad
      $error("position width must be 16..32 and analog width 1..16");
    end
  endgenerate

  // ****************************************
  // registers and decode
  // ****************************************
  logic [31:0] config_r;
  logic [31:0] gear_r;
  logic [1:0]  cap_flag_r;

  wire wr_config = WR_STB && (ADDR == servo_input_pkg::OFS_CONFIG);
  wire wr_gear   = WR_STB && (ADDR == servo_input_pkg::OFS_GEAR);
  wire wr_status = WR_STB && (ADDR == servo_input_pkg::OFS_STATUS);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      config_r <= servo_input_pkg::CONFIG_RST;
      gear_r   <= servo_input_pkg::GEAR_RST;
    end else begin
      if (wr_config) config_r <= WDATA;
      if (wr_gear) gear_r <= WDATA;
    end
  end

  // ****************************************
  // terminal function split
  // ****************************************
  wire [6:0] second = config_r[servo_input_pkg::CFG_SEL_LSB +: 7];
  wire       prog_op = config_r[servo_input_pkg::CFG_PROG_BIT];

  wire pen_second   = second[servo_input_pkg::SEL_PEN];
  wire cer_second   = second[servo_input_pkg::SEL_CER];
  wire ppi_second   = second[servo_input_pkg::SEL_PPI];
  wire ss1_second   = second[servo_input_pkg::SEL_SS1];
  wire ss2_second   = second[servo_input_pkg::SEL_SS2];
  wire srz_second   = second[servo_input_pkg::SEL_SRZ];
  wire probe_second = second[servo_input_pkg::SEL_PROBE];

  // each terminal feeds only its selected function
  wire pulse_train_gate       = PULSE_TRAIN_GATE && !pen_second;
  wire ahead_run_command      = PULSE_TRAIN_GATE && pen_second;
  wire position_error_clear   = POSITION_ERROR_CLEAR && !cer_second;
  wire backward_run_command   = POSITION_ERROR_CLEAR && cer_second;
  wire proportional_only_sel  = PROPORTIONAL_ONLY_SELECT && !ppi_second;
  wire loop_gain_swap         = PROPORTIONAL_ONLY_SELECT && ppi_second;
  wire speed_select_a         = SPEED_SELECT_A && !ss1_second;
  wire gear_ratio_two_select  = SPEED_SELECT_A && ss1_second;
  wire speed_select_b         = SPEED_SELECT_B && !ss2_second;
  wire turn_count_wipe        = SPEED_SELECT_B && ss2_second;
  wire zero_speed_clamp       = ZERO_SPEED_CLAMP && !srz_second;
  wire external_trip_input    = ZERO_SPEED_CLAMP && srz_second;
  wire control_law_select     = CONTROL_LAW_SELECT && !probe_second;
  wire homing_request         = HOMING_REQUEST && !probe_second;
  wire capture_input_a        = CONTROL_LAW_SELECT;
  wire capture_input_b        = HOMING_REQUEST;

  // ****************************************
  // control mode
  // ****************************************
  wire [1:0] mode_nxt = control_law_select ? config_r[servo_input_pkg::CFG_MODE_B +: 2]
                                           : config_r[servo_input_pkg::CFG_MODE_A +: 2];
  wire       pos_mode = (CTRL_MODE == servo_input_pkg::MODE_POS);

  // ****************************************
  // trip
  // ****************************************
  // set wins over reset so a trip still present is never dropped
  wire trip_nxt = external_trip_input ? 1'b1 :
                  ALARM_RESET         ? 1'b0 : TRIP;

  // ****************************************
  // multistage speed and run direction
  // ****************************************
  wire [1:0] stage_nxt = {speed_select_b, speed_select_a};
  wire       run_ok    = (stage_nxt != 2'b00) && !trip_nxt;
  // both directions at once is treated as stop
  wire       fwd_nxt   = run_ok && ahead_run_command && !backward_run_command;
  wire       bwd_nxt   = run_ok && backward_run_command && !ahead_run_command;

  // ****************************************
  // homing
  // ****************************************
  typedef enum logic [1:0] {H_IDLE, H_SEEK, H_ZONE} home_st_t;
  home_st_t home_r;
  home_st_t home_nxt;
  logic     home_req_prev_r;
  logic     homed_nxt;

  wire home_start = homing_request && !home_req_prev_r && pos_mode && !TRIP;

  always_comb begin
    home_nxt  = home_r;
    homed_nxt = HOMED;
    unique case (home_r)
      H_IDLE: begin
        if (home_start) begin
          home_nxt  = H_SEEK;
          homed_nxt = 1'b0;
        end
      end
      H_SEEK: begin
        if (HOME_ZONE_SWITCH) home_nxt = H_ZONE;
      end
      H_ZONE: begin
        // home reached on leaving the zone edge
        if (!HOME_ZONE_SWITCH) begin
          home_nxt  = H_IDLE;
          homed_nxt = 1'b1;
        end
      end
    endcase
    // homing is a position-mode operation; a mode change or trip aborts it
    if (!pos_mode || TRIP) begin
      home_nxt = H_IDLE;
    end
  end

  // ****************************************
  // pulse train, gear and error counter
  // ****************************************
  logic signed [POS_W-1:0] pend_r;
  logic                    gear2_prev_r;

  wire accept   = CMD_PULSE && pulse_train_gate;
  wire gear_sw  = gear_ratio_two_select != gear2_prev_r;
  wire [15:0] gear_num = GEAR_TWO ? gear_r[31:16] : gear_r[15:0];
  wire signed [POS_W-1:0] gear_step = POS_W'(signed'({1'b0, gear_num}));
  wire signed [POS_W-1:0] pend_one  = (pend_r > 0) ?  POS_W'(1) :
                                      (pend_r < 0) ? -POS_W'(1) : '0;
  wire signed [POS_W-1:0] pend_in   = !accept ? '0 : (CMD_DIR ? -POS_W'(1) : POS_W'(1));
  wire signed [POS_W-1:0] fb_in     = !FB_PULSE ? '0 : (FB_DIR ? -POS_W'(1) : POS_W'(1));
  wire signed [POS_W-1:0] cmd_move  = (pend_r > 0) ?  gear_step :
                                      (pend_r < 0) ? -gear_step : '0;

  // a gear change drops whatever pulses are still waiting
  wire signed [POS_W-1:0] pend_nxt = (gear_sw || position_error_clear) ? '0 :
                                     pend_r - pend_one + pend_in;
  wire signed [POS_W-1:0] err_nxt  = position_error_clear ? '0 :
                                     signed'(POS_ERROR) + cmd_move - fb_in;

  // ****************************************
  // analog routing
  // ****************************************
  wire spd_lim_sel = config_r[servo_input_pkg::CFG_SPD_LIM];
  wire trq_lim_sel = config_r[servo_input_pkg::CFG_TRQ_LIM];
  wire [1:0] spd_role_nxt =
      prog_op                                   ? servo_input_pkg::ROLE_GENERAL :
      (mode_nxt == servo_input_pkg::MODE_SPD)   ? servo_input_pkg::ROLE_CMD :
      spd_lim_sel                               ? servo_input_pkg::ROLE_LIMIT :
                                                  servo_input_pkg::ROLE_BIAS;
  wire [1:0] trq_role_nxt =
      prog_op                                   ? servo_input_pkg::ROLE_GENERAL :
      (mode_nxt == servo_input_pkg::MODE_TRQ)   ? servo_input_pkg::ROLE_CMD :
      trq_lim_sel                               ? servo_input_pkg::ROLE_LIMIT :
                                                  servo_input_pkg::ROLE_BIAS;
  // caps read zero when limiting is off so the loop never limits by accident
  wire [AN_W-1:0] fwd_cap_nxt = TORQUE_LIMIT_ENABLE ? ANALOG_FWD_TORQUE_CAP : '0;
  wire [AN_W-1:0] bwd_cap_nxt = TORQUE_LIMIT_ENABLE ? ANALOG_BWD_TORQUE_CAP : '0;

  // ****************************************
  // turn count wipe and captures
  // ****************************************
  logic wipe_fire;

  hold_qualifier #(
    .HOLD_CYC (WIPE_HOLD_CYCLES)
  ) u_wipe (
    .clk   (CORE_CLK),
    .nrst  (NRST),
    .level (turn_count_wipe),
    .fire  (wipe_fire)
  );

  logic [POS_W-1:0] cap_pos [2];
  logic [1:0]       cap_hit;
  wire  [1:0]       cap_in = {capture_input_b, capture_input_a};

  for (genvar g = 0; g < 2; g++) begin : g_cap
    edge_capture #(
      .W (POS_W)
    ) u_cap (
      .clk      (CORE_CLK),
      .nrst     (NRST),
      .enable   (probe_second),
      .probe    (cap_in[g]),
      .position (ACTUAL_POS),
      .held     (cap_pos[g]),
      .hit      (cap_hit[g])
    );
  end

  // a new capture wins over a write-one clear in the same cycle
  wire [1:0] cap_clr      = wr_status ? WDATA[servo_input_pkg::ST_CAP_LSB +: 2] : 2'b00;
  wire [1:0] cap_flag_nxt = cap_hit | (cap_flag_r & ~cap_clr);

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] status_word = {22'h0, cap_flag_r, 2'b00, SPEED_STAGE, GEAR_TWO,
                             HOMED, HOMING_ACTIVE, TRIP};
  wire [31:0] rd_nxt =
      (ADDR == servo_input_pkg::OFS_CONFIG)  ? config_r :
      (ADDR == servo_input_pkg::OFS_GEAR)    ? gear_r :
      (ADDR == servo_input_pkg::OFS_STATUS)  ? status_word :
      (ADDR == servo_input_pkg::OFS_POS_ERR) ? 32'(POS_ERROR) :
      (ADDR == servo_input_pkg::OFS_CAP_A)   ? 32'(cap_pos[0]) :
      (ADDR == servo_input_pkg::OFS_CAP_B)   ? 32'(cap_pos[1]) :
      (ADDR == servo_input_pkg::OFS_GEN_AN)  ? {16'(ANALOG_IN_TORQUE), 16'(ANALOG_IN_SPEED)} :
                                               32'h0000_0000;

  // ****************************************
  // state and outputs
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA           <= 32'h0000_0000;
      home_r          <= H_IDLE;
      home_req_prev_r <= 1'b0;
      gear2_prev_r    <= 1'b0;
      pend_r          <= '0;
      cap_flag_r      <= 2'b00;
      POS_ERROR       <= '0;
      CTRL_MODE       <= servo_input_pkg::MODE_POS;
      SPEED_STAGE     <= 2'b00;
      RUN_FWD         <= 1'b0;
      RUN_BWD         <= 1'b0;
      SPEED_CLAMP     <= 1'b0;
      P_ONLY          <= 1'b0;
      GAIN_ALT        <= 1'b0;
      GEAR_TWO        <= 1'b0;
      TRIP            <= 1'b0;
      OUTPUT_STOP     <= 1'b0;
      TURN_COUNT_CLEAR <= 1'b0;
      HOMING_ACTIVE   <= 1'b0;
      HOMED           <= 1'b0;
      SPEED_ANALOG    <= '0;
      SPEED_ROLE      <= servo_input_pkg::ROLE_CMD;
      TORQUE_ANALOG   <= '0;
      TORQUE_ROLE     <= servo_input_pkg::ROLE_CMD;
      TORQUE_LIMIT_ON <= 1'b0;
      FWD_TORQUE_CAP  <= '0;
      BWD_TORQUE_CAP  <= '0;
    end else begin
      RDATA           <= RD_STB ? rd_nxt : 32'h0000_0000;
      home_r          <= home_nxt;
      home_req_prev_r <= homing_request;
      gear2_prev_r    <= gear_ratio_two_select;
      pend_r          <= pend_nxt;
      cap_flag_r      <= cap_flag_nxt;
      POS_ERROR       <= err_nxt;
      CTRL_MODE       <= mode_nxt;
      SPEED_STAGE     <= stage_nxt;
      RUN_FWD         <= fwd_nxt;
      RUN_BWD         <= bwd_nxt;
      SPEED_CLAMP     <= zero_speed_clamp;
      P_ONLY          <= proportional_only_sel;
      GAIN_ALT        <= loop_gain_swap;
      GEAR_TWO        <= gear_ratio_two_select;
      TRIP            <= trip_nxt;
      OUTPUT_STOP     <= trip_nxt;
      TURN_COUNT_CLEAR <= wipe_fire;
      HOMING_ACTIVE   <= (home_nxt != H_IDLE);
      HOMED           <= homed_nxt;
      SPEED_ANALOG    <= ANALOG_IN_SPEED;
      SPEED_ROLE      <= spd_role_nxt;
      TORQUE_ANALOG   <= ANALOG_IN_TORQUE;
      TORQUE_ROLE     <= trq_role_nxt;
      TORQUE_LIMIT_ON <= TORQUE_LIMIT_ENABLE;
      FWD_TORQUE_CAP  <= fwd_cap_nxt;
      BWD_TORQUE_CAP  <= bwd_cap_nxt;
    end
  end

endmodule // servo_input_terminal_logic

// [verif/servo_input_asserts.sv]
module servo_input_asserts #(parameter int AN_W = 16) (
  // watched ports
  input wire logic            CORE_CLK,
  input wire logic            NRST,
  input wire logic            RD_STB,
  input wire logic [31:0]     RDATA,
  input wire logic            ALARM_RESET,
  input wire logic            TORQUE_LIMIT_ENABLE,
  input wire logic [AN_W-1:0] ANALOG_FWD_TORQUE_CAP,
  input wire logic [AN_W-1:0] FWD_TORQUE_CAP,
  input wire logic [AN_W-1:0] BWD_TORQUE_CAP,
  input wire logic [1:0]      SPEED_STAGE,
  input wire logic            RUN_FWD,
  input wire logic            RUN_BWD,
  input wire logic            TRIP,
  input wire logic            OUTPUT_STOP,
  input wire logic            TURN_COUNT_CLEAR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  trip_hold_a: assert property (TRIP && !ALARM_RESET |=> TRIP) else $error("trip lost");
  trip_stop_a: assert property (TRIP == OUTPUT_STOP) else $error("stop differs");
  // two cycles, although run outputs use trip_nxt and so drop in the same cycle as TRIP rises
  trip_run_a: assert property (TRIP [*2] |-> !RUN_FWD && !RUN_BWD) else $error("run in trip");
  stage_stop_a: assert property ((SPEED_STAGE == 2'h0) [*2] |-> !RUN_FWD && !RUN_BWD)
    else $error("run at stage 0");
  fwd_cap_a: assert property (TORQUE_LIMIT_ENABLE |=> FWD_TORQUE_CAP == $past(ANALOG_FWD_TORQUE_CAP))
    else $error("fwd cap");
  cap_off_a: assert property (!TORQUE_LIMIT_ENABLE |=> FWD_TORQUE_CAP == '0 && BWD_TORQUE_CAP == '0)
    else $error("cap not off");
  wipe_once_a: assert property (TURN_COUNT_CLEAR |=> !TURN_COUNT_CLEAR [*8]) else $error("wipe");
  rd_idle_a: assert property (!RD_STB |=> RDATA == 32'h0) else $error("rdata not idle");
endmodule // servo_input_asserts

bind servo_input_terminal_logic servo_input_asserts #(.AN_W(AN_W)) chk (.*);

// [verif/host_pulser.sv]
module host_pulser (
  // host side of the pulse-train command
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       start,
  input wire logic [7:0] n,
  output logic           pulse,
  output logic           busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  assign busy = cnt_r != 8'h00;
  // a gap after each pulse, as a slow host would send them
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) {cnt_r, pulse} <= 9'h000;
    else if (start) cnt_r <= n;
    else {cnt_r, pulse} <= {cnt_r - {7'h00, busy && !pulse}, busy && !pulse};
endmodule // host_pulser

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK, NRST, WR_STB, RD_STB, HOME_ZONE_SWITCH, HOMING_REQUEST, PULSE_TRAIN_GATE;
  logic POSITION_ERROR_CLEAR, PROPORTIONAL_ONLY_SELECT, SPEED_SELECT_A, SPEED_SELECT_B;
  logic ZERO_SPEED_CLAMP, CONTROL_LAW_SELECT, TORQUE_LIMIT_ENABLE, ALARM_RESET, CMD_PULSE;
  logic CMD_DIR, FB_PULSE, FB_DIR, RUN_FWD, RUN_BWD, SPEED_CLAMP, P_ONLY, GAIN_ALT, GEAR_TWO;
  logic TRIP, OUTPUT_STOP, TURN_COUNT_CLEAR, HOMING_ACTIVE, HOMED, TORQUE_LIMIT_ON, start, busy;
  logic [1:0]  CTRL_MODE, SPEED_STAGE, SPEED_ROLE, TORQUE_ROLE;
  logic [7:0]  ADDR, n;
  logic [15:0] ANALOG_IN_SPEED, ANALOG_IN_TORQUE, ANALOG_FWD_TORQUE_CAP, ANALOG_BWD_TORQUE_CAP;
  logic [15:0] SPEED_ANALOG, TORQUE_ANALOG, FWD_TORQUE_CAP, BWD_TORQUE_CAP;
  logic [31:0] WDATA, RDATA, ACTUAL_POS, POS_ERROR;
  int          errors, n_tests, cycles, wipes, t, g;
  servo_input_terminal_logic #(.WIPE_HOLD_CYCLES(64'd20)) dut (.*);
  host_pulser host (.clk(CORE_CLK), .nrst(NRST), .start(start), .n(n), .pulse(CMD_PULSE), .busy(busy));
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cycles++;
    if (TURN_COUNT_CLEAR === 1'b1) wipes++;
    if (cycles == 3000) begin
      errors++;
      final_report;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task st;
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK) {ADDR, WDATA, WR_STB} <= {a, d, 1'b1};
    @(posedge CORE_CLK) WR_STB <= 1'b0;
  endtask
  task cfg(input logic [31:0] d);
    wr(servo_input_pkg::OFS_CONFIG, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CORE_CLK) {ADDR, RD_STB} <= {a, 1'b1};
    @(posedge CORE_CLK) RD_STB <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  task pulses(input logic [7:0] k);
    @(posedge CORE_CLK) {n, start} <= {k, 1'b1};
    @(posedge CORE_CLK) start <= 1'b0;
    #1;
    while (busy) #10;
    repeat (2) st;
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {NRST, WR_STB, RD_STB, ADDR, WDATA, HOME_ZONE_SWITCH, HOMING_REQUEST, PULSE_TRAIN_GATE,
     POSITION_ERROR_CLEAR, PROPORTIONAL_ONLY_SELECT, SPEED_SELECT_A, SPEED_SELECT_B,
     ZERO_SPEED_CLAMP, CONTROL_LAW_SELECT, TORQUE_LIMIT_ENABLE, ALARM_RESET, CMD_DIR, FB_PULSE,
     FB_DIR, ACTUAL_POS, ANALOG_FWD_TORQUE_CAP, ANALOG_BWD_TORQUE_CAP, start, n} = 0;
    {ANALOG_IN_SPEED, ANALOG_IN_TORQUE} = 32'h0555_0aaa;
    repeat (3) @(posedge CORE_CLK);
    NRST <= 1'b1;
    rd(servo_input_pkg::OFS_CONFIG, servo_input_pkg::CONFIG_RST);
    rd(servo_input_pkg::OFS_GEAR, servo_input_pkg::GEAR_RST);
    rd(8'h40, 32'h0);
    $display("test %0d done", ++g);
    @(posedge CORE_CLK) {HOMING_REQUEST, HOME_ZONE_SWITCH} <= 2'b11;
    st;
    chk(HOMING_ACTIVE, 1'b1);
    @(posedge CORE_CLK) HOME_ZONE_SWITCH <= 1'b0;
    st;
    chk({HOMING_ACTIVE, HOMED}, 2'b01);
    $display("test %0d done", ++g);
    @(posedge CORE_CLK) PULSE_TRAIN_GATE <= 1'b1;
    pulses(8'd5);
    chk(POS_ERROR, 32'd5);
    @(posedge CORE_CLK) PULSE_TRAIN_GATE <= 1'b0;
    pulses(8'd3);
    chk(POS_ERROR, 32'd5);
    rd(servo_input_pkg::OFS_POS_ERR, 32'd5);
    @(posedge CORE_CLK) POSITION_ERROR_CLEAR <= 1'b1;
    st;
    chk(POS_ERROR, 32'd0);
    @(posedge CORE_CLK) {POSITION_ERROR_CLEAR, SPEED_SELECT_A} <= 2'b01;
    st;
    chk(SPEED_STAGE, 2'h1);
    $display("test %0d done", ++g);
    // gate and clear terminals switched to their run functions
    cfg(32'h03);
    @(posedge CORE_CLK) PULSE_TRAIN_GATE <= 1'b1;
    st;
    chk(RUN_FWD, 1'b1);
    @(posedge CORE_CLK) {PULSE_TRAIN_GATE, POSITION_ERROR_CLEAR} <= 2'b01;
    st;
    chk(RUN_BWD, 1'b1);
    @(posedge CORE_CLK) SPEED_SELECT_A <= 1'b0;
    st;
    chk(RUN_BWD, 1'b0);
    cfg(32'h0c);
    @(posedge CORE_CLK) {PROPORTIONAL_ONLY_SELECT, SPEED_SELECT_A, POSITION_ERROR_CLEAR} <= 3'b110;
    st;
    chk({GAIN_ALT, P_ONLY, GEAR_TWO}, 3'b101);
    cfg(32'h00);
    st;
    chk({GAIN_ALT, P_ONLY}, 2'b01);
    $display("test %0d done", ++g);
    cfg(32'h20);
    @(posedge CORE_CLK) ZERO_SPEED_CLAMP <= 1'b1;
    st;
    chk(TRIP, 1'b1);
    @(posedge CORE_CLK) ZERO_SPEED_CLAMP <= 1'b0;
    st;
    chk(TRIP, 1'b1);
    @(posedge CORE_CLK) ALARM_RESET <= 1'b1;
    st;
    chk(TRIP, 1'b0);
    @(posedge CORE_CLK) {ALARM_RESET, TORQUE_LIMIT_ENABLE, ANALOG_FWD_TORQUE_CAP,
      ANALOG_BWD_TORQUE_CAP} <= {2'b01, 32'h0abc_0123};
    st;
    chk({FWD_TORQUE_CAP, BWD_TORQUE_CAP}, 32'h0abc_0123);
    chk(TORQUE_LIMIT_ON, 1'b1);
    @(posedge CORE_CLK) TORQUE_LIMIT_ENABLE <= 1'b0;
    st;
    chk({FWD_TORQUE_CAP, BWD_TORQUE_CAP}, 32'h0);
    // speed mode from mode A, torque input as limit, clamp terminal back to primary
    cfg(32'h2100);
    @(posedge CORE_CLK) ZERO_SPEED_CLAMP <= 1'b1;
    st;
    chk({CTRL_MODE, SPEED_ROLE, TORQUE_ROLE, SPEED_CLAMP, TRIP}, 8'h4a);
    cfg(32'h80);
    st;
    chk({SPEED_ROLE, TORQUE_ROLE}, 4'hf);
    chk({SPEED_ANALOG, TORQUE_ANALOG}, 32'h0555_0aaa);
    rd(servo_input_pkg::OFS_GEN_AN, 32'h0aaa_0555);
    $display("test %0d done", ++g);
    // a short hold must not wipe, a long one wipes once
    cfg(32'h10);
    for (t = 0; t < 3; t++) begin
      @(posedge CORE_CLK) SPEED_SELECT_B <= 1'b1;
      repeat (19 + t / 2) @(posedge CORE_CLK);
      SPEED_SELECT_B <= 1'b0;
      st;
      chk(wipes, t / 2);
    end
    cfg(32'h40);
    for (t = 0; t < 2; t++) begin
      @(posedge CORE_CLK) {ACTUAL_POS, CONTROL_LAW_SELECT, HOMING_REQUEST} <=
        {32'h1234 << t, ~t[0], t[0]};
      st;
      rd(servo_input_pkg::OFS_CAP_A, 32'h1234 << t);
      rd(servo_input_pkg::OFS_CAP_B, 32'h1234 << t);
    end
    rd(servo_input_pkg::OFS_STATUS, 32'h314);
    wr(servo_input_pkg::OFS_STATUS, 32'h100);
    rd(servo_input_pkg::OFS_STATUS, 32'h214);
    $display("test %0d done", ++g);
    final_report;
  end
endmodule // testbench
